// ===== inc/lid_pkg.sv
// Purpose: Shared types and constants of the display instruction decoder.
// Assumes: One clock; execution times counted in ref_clk cycles.
// Notes: Command masks pair with values; a command matches when (cmd & mask) == value.
package lid_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Control byte layout
    localparam int CTRL_CONT_BIT = 7;
    localparam int CTRL_RS_BIT = 6;
    localparam logic [7:0] CTRL_ZERO_MASK = 8'h3f;

    ////////////////////////////////////////////////////////////////////////////////
    // Execution times in clock cycles
    localparam logic [7:0] EXEC_SHORT = 8'h03;
    localparam logic [7:0] EXEC_CLEAR = 8'ha5;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction encodings
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_CLEAR = 8'h01;
    localparam logic [7:0] OP_HOME = 8'h02;
    localparam logic [7:0] FSET_MASK = 8'hea;
    localparam logic [7:0] FSET_VAL = 8'h20;
    localparam logic [7:0] ENTRY_MASK = 8'hfc;
    localparam logic [7:0] ENTRY_VAL = 8'h04;
    localparam logic [7:0] DCTL_MASK = 8'hf8;
    localparam logic [7:0] DCTL_VAL = 8'h08;
    localparam logic [7:0] SHIFT_MASK = 8'hf3;
    localparam logic [7:0] SHIFT_VAL = 8'h10;
    localparam logic [7:0] CGADR_MASK = 8'hc0;
    localparam logic [7:0] CGADR_VAL = 8'h40;
    localparam logic [7:0] SCREEN_MASK = 8'hfe;
    localparam logic [7:0] SCREEN_VAL = 8'h02;
    localparam logic [7:0] DCFG_MASK = 8'hfc;
    localparam logic [7:0] DCFG_VAL = 8'h04;
    localparam logic [7:0] ICON_MASK = 8'hf9;
    localparam logic [7:0] ICON_VAL = 8'h08;
    localparam logic [7:0] TEMP_MASK = 8'hfc;
    localparam logic [7:0] TEMP_VAL = 8'h10;

    // Field positions inside command bytes
    localparam int B_DL = 4;
    localparam int B_M = 2;
    localparam int B_H = 0;
    localparam int B_ID = 1;
    localparam int B_S = 0;
    localparam int B_D = 2;
    localparam int B_C = 1;
    localparam int B_B = 0;
    localparam int B_SC = 3;
    localparam int B_RL = 2;
    localparam int B_ADR_TOP = 7;
    localparam int B_L = 0;
    localparam int B_P = 1;
    localparam int B_Q = 0;
    localparam int B_IM = 2;
    localparam int B_IB = 1;
    localparam int B_TC1 = 1;
    localparam int B_TC2 = 0;
    localparam int B_VSEL = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // Memory geometry and fill
    localparam int ADDR_W = 7;
    localparam int RAM_DEPTH = 128;
    localparam logic [6:0] ADDR_LAST = 7'h7f;
    localparam logic [7:0] BLANK_CODE = 8'h20;

    typedef enum logic [2:0] {
        LID_P_IDLE = 3'b000,
        LID_P_CTRL = 3'b001,
        LID_P_CMD = 3'b010,
        LID_P_LAST = 3'b011,
        LID_P_SKIP = 3'b100,
        LID_P_READ = 3'b101
    } lid_parse_e;

    typedef struct packed {
        logic interface_width;
        logic two_line;
        logic ext_set;
        logic entry_inc;
        logic shift_en;
        logic display_on;
        logic cursor_on;
        logic cursor_blink;
        logic screen_mirror;
        logic column_rev;
        logic row_rev;
        logic icon_only_mode;
        logic icon_blink;
        logic temp_coeff_hi;
        logic temp_coeff_lo;
        logic [5:0] volt_a;
        logic [5:0] volt_b;
    } lid_cfg_s;

    localparam lid_cfg_s CFG_RESET = '{interface_width: 1'b1, entry_inc: 1'b1, default: '0};

    // Bytes and strobes from the bus slave front end, same clock
    typedef struct packed {
        logic frame_start;
        logic frame_rnw;
        logic byte_valid;
        logic [7:0] byte_data;
        logic rd_req;
        logic frame_stop;
    } lid_rx_s;

    typedef struct packed {
        logic busy_flag;
        logic [6:0] address_counter;
        logic [6:0] display_shift;
        logic pattern_sel;
    } lid_status_s;

    typedef struct packed {
        lid_parse_e parse;
        logic register_select;
        logic continuation_flag;
        lid_cfg_s cfg;
        logic [6:0] ac;
        logic to_pattern;
        logic [6:0] shift;
        logic [7:0] rd_data;
        logic rd_valid;
        logic clearing;
        logic [6:0] clr_idx;
    } lid_dec_state_s;

    typedef struct packed {
        logic [7:0] count;
    } lid_timer_state_s;

endpackage

// ===== rtl/lid_ram.sv
// Purpose: Byte array for display or pattern memory.
// Assumes: Write on the clock edge, read is combinational.
// Notes: No reset; contents are undefined until written or cleared.
module lid_ram (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem [lid_pkg::RAM_DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Combinational read lets the decoder register the byte in one cycle
    assign rd_data = mem[rd_addr];

endmodule

// ===== rtl/lid_busy_timer.sv
// Purpose: Execution timer that holds the busy flag.
// Assumes: start is a one-cycle pulse from the decoder.
// Notes: Busy is high exactly load_cycles cycles after the start edge.
module lid_busy_timer (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [7:0] load_cycles,
    output logic busy_flag
);

    lid_pkg::lid_timer_state_s s;
    lid_pkg::lid_timer_state_s next_s;

    always_comb begin
        next_s = s;
        if (start) begin
            next_s.count = load_cycles;
        end else if (s.count != 8'h00) begin
            next_s.count = s.count - 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy_flag = (s.count != 8'h00);

    chk_timer_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
        start |=> s.count == $past(load_cycles))
        else $error("timer did not load execution time");

endmodule

// ===== rtl/lid_decoder.sv
// Purpose: Instruction interpreter of a character display controller.
// Assumes: Bus slave front end on ref_clk delivers received bytes and read requests.
// Notes: Execution cycles are ref_clk cycles; clear sweeps all display memory.

////////////////////////////////////////////////////////////////////////////////
module lid_decoder (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire lid_pkg::lid_rx_s rx,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output lid_pkg::lid_cfg_s cfg,
    output lid_pkg::lid_status_s status,
    output logic power_down
);

    lid_pkg::lid_dec_state_s s;
    lid_pkg::lid_dec_state_s next_s;

    logic busy_flag;
    logic timer_start;
    logic [7:0] timer_load;
    logic disp_wr_en;
    logic pat_wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] disp_q;
    logic [7:0] pat_q;
    logic [7:0] ram_q;
    logic [7:0] cmd;
    logic exec_byte;
    logic accept;
    logic read_req;

    function automatic logic is_op(input logic [7:0] c, input logic [7:0] mask,
                                   input logic [7:0] val);
        is_op = ((c & mask) == val);
    endfunction

    function automatic logic [6:0] step(input logic [6:0] a, input logic up);
        step = up ? a + 7'h01 : a - 7'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Memories and execution timer

    lid_ram u_display_ram (
        .ref_clk(ref_clk),
        .wr_en(disp_wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(s.ac),
        .rd_data(disp_q)
    );

    lid_ram u_pattern_ram (
        .ref_clk(ref_clk),
        .wr_en(pat_wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(s.ac),
        .rd_data(pat_q)
    );

    lid_busy_timer u_busy_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(timer_start),
        .load_cycles(timer_load),
        .busy_flag(busy_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Byte stream decode

    assign cmd = rx.byte_data;
    assign ram_q = s.to_pattern ? pat_q : disp_q;
    assign exec_byte = rx.byte_valid && !rx.frame_start && !rx.frame_stop
                       && (s.parse == lid_pkg::LID_P_CMD || s.parse == lid_pkg::LID_P_LAST);
    assign accept = exec_byte && !busy_flag;
    assign read_req = rx.rd_req && (s.parse == lid_pkg::LID_P_READ);

    always_comb begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        timer_start = 1'b0;
        timer_load = lid_pkg::EXEC_SHORT;
        disp_wr_en = 1'b0;
        pat_wr_en = 1'b0;
        wr_addr = s.ac;
        wr_data = cmd;

        // Blank sweep runs under busy, so it never meets a data write
        if (s.clearing) begin
            disp_wr_en = 1'b1;
            wr_addr = s.clr_idx;
            wr_data = lid_pkg::BLANK_CODE;
            next_s.clr_idx = s.clr_idx + 7'h01;
            if (s.clr_idx == lid_pkg::ADDR_LAST) begin
                next_s.clearing = 1'b0;
            end
        end

        if (rx.frame_start) begin
            next_s.parse = rx.frame_rnw ? lid_pkg::LID_P_READ : lid_pkg::LID_P_CTRL;
        end else if (rx.frame_stop) begin
            next_s.parse = lid_pkg::LID_P_IDLE;
        end else if (rx.byte_valid) begin
            unique case (s.parse)
                lid_pkg::LID_P_CTRL: begin
                    // Malformed control byte: drop the rest of the frame
                    if ((cmd & lid_pkg::CTRL_ZERO_MASK) != 8'h00) begin
                        next_s.parse = lid_pkg::LID_P_SKIP;
                    end else begin
                        next_s.register_select = cmd[lid_pkg::CTRL_RS_BIT];
                        next_s.continuation_flag = cmd[lid_pkg::CTRL_CONT_BIT];
                        next_s.parse = lid_pkg::LID_P_CMD;
                    end
                end
                lid_pkg::LID_P_CMD: begin
                    next_s.parse = s.continuation_flag ? lid_pkg::LID_P_CTRL
                                                       : lid_pkg::LID_P_LAST;
                end
                lid_pkg::LID_P_IDLE, lid_pkg::LID_P_LAST, lid_pkg::LID_P_SKIP,
                lid_pkg::LID_P_READ: begin
                    next_s.parse = s.parse;
                end
                default: begin
                    next_s.parse = lid_pkg::LID_P_IDLE;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Execution of an accepted byte
        if (accept) begin
            timer_start = 1'b1;
            if (s.register_select) begin
                // Data byte lands in whichever memory the last address picked
                pat_wr_en = s.to_pattern;
                disp_wr_en = !s.to_pattern;
                next_s.ac = step(s.ac, s.cfg.entry_inc);
                if (s.cfg.shift_en && !s.to_pattern) begin
                    next_s.shift = step(s.shift, s.cfg.entry_inc);
                end
            end else if (cmd == lid_pkg::OP_NOP) begin
                next_s.ac = s.ac;
            end else if (is_op(cmd, lid_pkg::FSET_MASK, lid_pkg::FSET_VAL)) begin
                next_s.cfg.interface_width = cmd[lid_pkg::B_DL];
                next_s.cfg.two_line = cmd[lid_pkg::B_M];
                next_s.cfg.ext_set = cmd[lid_pkg::B_H];
            end else if (!s.cfg.ext_set) begin
                if (cmd == lid_pkg::OP_CLEAR) begin
                    timer_load = lid_pkg::EXEC_CLEAR;
                    next_s.clearing = 1'b1;
                    next_s.clr_idx = '0;
                    next_s.ac = '0;
                    next_s.shift = '0;
                    next_s.to_pattern = 1'b0;
                end else if (cmd == lid_pkg::OP_HOME) begin
                    next_s.ac = '0;
                    next_s.shift = '0;
                    next_s.to_pattern = 1'b0;
                end else if (is_op(cmd, lid_pkg::ENTRY_MASK, lid_pkg::ENTRY_VAL)) begin
                    next_s.cfg.entry_inc = cmd[lid_pkg::B_ID];
                    next_s.cfg.shift_en = cmd[lid_pkg::B_S];
                end else if (is_op(cmd, lid_pkg::DCTL_MASK, lid_pkg::DCTL_VAL)) begin
                    next_s.cfg.display_on = cmd[lid_pkg::B_D];
                    next_s.cfg.cursor_on = cmd[lid_pkg::B_C];
                    next_s.cfg.cursor_blink = cmd[lid_pkg::B_B];
                end else if (is_op(cmd, lid_pkg::SHIFT_MASK, lid_pkg::SHIFT_VAL)) begin
                    if (cmd[lid_pkg::B_SC]) begin
                        next_s.shift = step(s.shift, cmd[lid_pkg::B_RL]);
                    end else begin
                        next_s.ac = step(s.ac, cmd[lid_pkg::B_RL]);
                    end
                end else if (is_op(cmd, lid_pkg::CGADR_MASK, lid_pkg::CGADR_VAL)) begin
                    // Top address bit is kept; only the display address sets it
                    next_s.ac = {s.ac[lid_pkg::ADDR_W-1], cmd[5:0]};
                    next_s.to_pattern = 1'b1;
                end else if (cmd[lid_pkg::B_ADR_TOP]) begin
                    next_s.ac = cmd[6:0];
                    next_s.to_pattern = 1'b0;
                end
            end else begin
                // Reserved extended codes change no setting but still start the busy timer
                if (is_op(cmd, lid_pkg::SCREEN_MASK, lid_pkg::SCREEN_VAL)) begin
                    next_s.cfg.screen_mirror = cmd[lid_pkg::B_L];
                end else if (is_op(cmd, lid_pkg::DCFG_MASK, lid_pkg::DCFG_VAL)) begin
                    next_s.cfg.column_rev = cmd[lid_pkg::B_P];
                    next_s.cfg.row_rev = cmd[lid_pkg::B_Q];
                end else if (is_op(cmd, lid_pkg::ICON_MASK, lid_pkg::ICON_VAL)) begin
                    next_s.cfg.icon_only_mode = cmd[lid_pkg::B_IM];
                    next_s.cfg.icon_blink = cmd[lid_pkg::B_IB];
                end else if (is_op(cmd, lid_pkg::TEMP_MASK, lid_pkg::TEMP_VAL)) begin
                    next_s.cfg.temp_coeff_hi = cmd[lid_pkg::B_TC1];
                    next_s.cfg.temp_coeff_lo = cmd[lid_pkg::B_TC2];
                end else if (cmd[lid_pkg::B_ADR_TOP]) begin
                    if (cmd[lid_pkg::B_VSEL]) begin
                        next_s.cfg.volt_b = cmd[5:0];
                    end else begin
                        next_s.cfg.volt_a = cmd[5:0];
                    end
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Read requests
        if (read_req) begin
            next_s.rd_valid = 1'b1;
            if (!s.register_select) begin
                next_s.rd_data = {busy_flag, s.ac};
            end else if (!busy_flag) begin
                timer_start = 1'b1;
                next_s.rd_data = ram_q;
                next_s.ac = step(s.ac, s.cfg.entry_inc);
                if (s.cfg.shift_en && !s.to_pattern) begin
                    next_s.shift = step(s.shift, s.cfg.entry_inc);
                end
            end else begin
                // Busy data read is not executed; host sees zero
                next_s.rd_data = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{parse: lid_pkg::LID_P_IDLE, cfg: lid_pkg::CFG_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rd_data = s.rd_data;
    assign rd_valid = s.rd_valid;
    assign cfg = s.cfg;
    assign power_down = !s.cfg.display_on;
    assign status.busy_flag = busy_flag;
    assign status.address_counter = s.ac;
    assign status.display_shift = s.shift;
    assign status.pattern_sel = s.to_pattern;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    chk_short_busy_len: assert property (
        timer_start && timer_load == lid_pkg::EXEC_SHORT |=> busy_flag [*3] ##1 !busy_flag)
        else $error("short instruction busy time wrong");

    chk_clear_busy_len: assert property (
        accept && !s.register_select && !s.cfg.ext_set && cmd == lid_pkg::OP_CLEAR
        |-> ##165 busy_flag ##1 !busy_flag)
        else $error("clear busy time wrong");

    chk_busy_drops_cmd: assert property (
        exec_byte && busy_flag && !read_req |=> $stable(s.cfg) && $stable(s.ac))
        else $error("instruction executed while busy");

    chk_write_steps_ac: assert property (
        accept && s.register_select
        |=> s.ac == ($past(s.cfg.entry_inc) ? $past(s.ac) + 7'h01 : $past(s.ac) - 7'h01))
        else $error("address counter did not step after write");

    chk_status_read: assert property (
        read_req && !s.register_select
        |=> rd_valid && rd_data == {$past(busy_flag), $past(s.ac)})
        else $error("status read returned wrong byte");

    chk_ctrl_malformed: assert property (
        rx.byte_valid && !rx.frame_start && !rx.frame_stop && s.parse == lid_pkg::LID_P_CTRL
        && (cmd & lid_pkg::CTRL_ZERO_MASK) != 8'h00 |=> s.parse == lid_pkg::LID_P_SKIP)
        else $error("malformed control byte accepted");

    chk_dir_from_addr: assert property (
        rx.frame_start
        |=> s.parse == ($past(rx.frame_rnw) ? lid_pkg::LID_P_READ : lid_pkg::LID_P_CTRL))
        else $error("frame direction not taken from address");

    chk_last_ctrl: assert property (
        rx.byte_valid && !rx.frame_start && !rx.frame_stop && s.parse == lid_pkg::LID_P_CMD
        && !s.continuation_flag |=> s.parse == lid_pkg::LID_P_LAST)
        else $error("last control byte not honoured");

    chk_home_zero: assert property (
        accept && !s.register_select && !s.cfg.ext_set && cmd == lid_pkg::OP_HOME
        |=> s.ac == 7'h00 && s.shift == 7'h00 ##1 busy_flag)
        else $error("return home did not reset counter");

    // Top counter bit must survive, or pattern rows above 63 become unreachable
    chk_cgadr_keeps_top: assert property (
        accept && !s.register_select && !s.cfg.ext_set
        && is_op(cmd, lid_pkg::CGADR_MASK, lid_pkg::CGADR_VAL)
        |=> s.ac[lid_pkg::ADDR_W-1] == $past(s.ac[lid_pkg::ADDR_W-1]) && s.to_pattern)
        else $error("pattern address changed top counter bit");

    chk_entry_shift: assert property (
        accept && s.register_select && s.cfg.shift_en && !s.to_pattern
        |=> s.shift == ($past(s.cfg.entry_inc) ? $past(s.shift) + 7'h01 : $past(s.shift) - 7'h01))
        else $error("display did not shift on data write");

endmodule

// ===== tb/lid_host.sv
// Purpose: Host model that feeds received bytes and read requests.
// Assumes: rx changes 1 ns after the rising edge.
// Notes: Waits out execution time instead of polling busy.
module lid_host (
    input wire logic ref_clk,
    output lid_pkg::lid_rx_s rx,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial rx = '0;
    //////////////////////////////////////////
    task automatic drive(input lid_pkg::lid_rx_s r);
        @(posedge ref_clk);
        #1 rx = r;
    endtask
    task automatic start(input logic rnw);
        drive('{frame_start: 1'b1, frame_rnw: rnw, default: '0});
    endtask
    task automatic stop();
        drive('{frame_stop: 1'b1, default: '0});
        drive('0);
    endtask
    task automatic put(input logic [7:0] b);
        drive('{byte_valid: 1'b1, byte_data: b, default: '0});
    endtask
    // Reserved extended codes are never sent
    task automatic wr(input logic rs, input logic [7:0] b0, input logic [7:0] b1,
        input logic two, input int idle);
        start(1'b0);
        put({1'b0, rs, 6'h00});
        put(b0);
        if (two) put(b1);
        stop();
        repeat (idle) @(posedge ref_clk);
        // Return off the edge so callers see settled outputs
        #1;
    endtask
    task automatic rd(input logic rs, output logic [7:0] d, output logic v);
        start(1'b0);
        put({1'b0, rs, 6'h00});
        stop();
        start(1'b1);
        drive('{rd_req: 1'b1, default: '0});
        drive('0);
        v = rd_valid;
        d = rd_data;
        stop();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench of the instruction decoder.
// Assumes: Commands spaced by idle cycles that cover busy time, except the second byte of the one two-byte frame, which is sent while busy.
// Notes: Busy run length measured by a cycle counter.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk;
    logic reset_n;
    lid_pkg::lid_rx_s rx;
    logic [7:0] rd_data;
    logic rd_valid;
    lid_pkg::lid_cfg_s cfg;
    lid_pkg::lid_status_s status;
    logic power_down;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int run = 0;
    int last_busy = 0;
    int n_runs = 0;
    int k;
    logic [7:0] d;
    logic v;
    lid_decoder dut (.ref_clk(ref_clk), .reset_n(reset_n), .rx(rx), .rd_data(rd_data),
        .rd_valid(rd_valid), .cfg(cfg), .status(status), .power_down(power_down));
    lid_host host (.ref_clk(ref_clk), .rx(rx), .rd_data(rd_data), .rd_valid(rd_valid));
    //////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Length of the last busy run, in cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (status.busy_flag === 1'b1) run <= run + 1;
        else begin
            if (run != 0) begin
                last_busy <= run;
                n_runs <= n_runs + 1;
            end
            run <= 0;
        end
        // Ceiling about seventeen times the expected run length of the test, about 480 cycles
        if (cycles == 8000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmd(input logic rs, input logic [7:0] b);
        host.wr(rs, b, 8'h00, 1'b0, 4);
    endtask
    //////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        chk("cfg", 32'(lid_pkg::CFG_RESET), 32'(cfg));
        chk("pdown", 1, 32'(power_down));
        cmd(0, 8'h35);
        chk("fset", 3'b111, {cfg.interface_width, cfg.two_line, cfg.ext_set});
        chk("busy", 3, last_busy);
        cmd(0, 8'h03);
        cmd(0, 8'h07);
        cmd(0, 8'h0e);
        cmd(0, 8'h13);
        cmd(0, 8'haa);
        cmd(0, 8'hd5);
        chk("ext", 7'h7f, {cfg.screen_mirror, cfg.column_rev, cfg.row_rev, cfg.icon_only_mode,
            cfg.icon_blink, cfg.temp_coeff_hi, cfg.temp_coeff_lo});
        chk("volt", 12'ha95, {cfg.volt_a, cfg.volt_b});
        cmd(0, 8'h30);
        chk("basic", 0, 32'(cfg.ext_set));
        host.wr(0, 8'h0f, 8'h08, 1'b1, 4);
        chk("dctl", 4'b1110,
            {cfg.display_on, cfg.cursor_on, cfg.cursor_blink, power_down});
        // A new busy run proves the nop was timed, not just the old length
        k = n_runs;
        cmd(0, 8'h00);
        chk("nop", 3, last_busy);
        chk("nop_runs", k + 1, n_runs);
        cmd(0, 8'h85);
        cmd(0, 8'h06);
        cmd(1, 8'h41);
        cmd(1, 8'h42);
        chk("ac_inc", 7, 32'(status.address_counter));
        cmd(0, 8'h04);
        cmd(1, 8'h43);
        chk("ac_dec", 6, 32'(status.address_counter));
        host.rd(0, d, v);
        chk("stat", 9'h106, {v, d});
        cmd(0, 8'h85);
        host.rd(1, d, v);
        chk("rdat", 9'h141, {v, d});
        chk("ac_rd", 4, 32'(status.address_counter));
        cmd(0, 8'h1c);
        chk("shift", 11'h014, {status.display_shift, status.address_counter[3:0]});
        cmd(0, 8'h02);
        chk("home", 0, {status.display_shift, status.address_counter});
        cmd(0, 8'h07);
        cmd(1, 8'h33);
        chk("eshift", 14'h0081, {status.display_shift, status.address_counter});
        // Top counter bit set first so the pattern address must keep it
        cmd(0, 8'hc0);
        cmd(0, 8'h45);
        chk("cgadr", 8'hc5, {status.pattern_sel, status.address_counter});
        cmd(1, 8'h1f);
        cmd(0, 8'h45);
        host.rd(1, d, v);
        chk("cgdat", 9'h11f, {v, d});
        host.wr(0, 8'h01, 8'h00, 1'b0, 170);
        chk("clr", 165, last_busy);
        chk("clr_ac", 0, {status.pattern_sel, status.address_counter});
        cmd(0, 8'h85);
        host.rd(1, d, v);
        chk("blank", 9'h120, {v, d});
        print_verdict();
    end
endmodule
